/* common/fspfe_defs.svh */
// Constants of the serial flash pin front end: register indices, fields, pin slots.
// Assumes a 20 MHz system clock that oversamples all pins through two flip-flops.
// Notes on behaviour
// - Select high: deselect, all outputs high impedance, enter standby.
// - Select high: instruction, address and data input are ignored.
// - A new instruction is accepted only after a select falling transition.
// - Single width: host bits on data line 0 are sampled on rising clock.
// - Single width: read data or status change on data line 1 at falling clock.
// - Dual and quad: lines are bidirectional; sample on rise, drive from fall.
// - Quad width uses the protect pin as line 2, pause/reset pin as line 3.
// - Lock bit set and protect pin low: lock, quad and protect bits unwritable.
// - Lock bit clear: status writes allowed whatever the protect pin level.
// - Quad enable set: protect function off, pin is only data line 2.
// - Quad enable set: pause and reset functions off, pin is only line 3.
// - No dedicated reset: shared pin is pause when select bit 0, reset when 1.
// - Dedicated reset enabled: shared pin is pause whatever the select bit.
// - Pause low while selected suspends transfer, keeps sequence, resumes on high.
// - Pause low and select low: serial output held in high impedance.
// - Function register bit 0 set disables the dedicated reset pin.
// - Reset pin low: reset mode with outputs high impedance, normal when high.
`ifndef FSPFE_DEFS_SVH
`define FSPFE_DEFS_SVH

`define FSP_REG_STATUS   3'h0
`define FSP_REG_FUNC     3'h1
`define FSP_REG_RDPARAM  3'h2
`define FSP_REG_CTRL     3'h3
`define FSP_REG_TXDATA   3'h4
`define FSP_REG_RXDATA   3'h5

`define FSP_ST_LOCK      7
`define FSP_ST_QE        6
`define FSP_STATUS_MASK  8'hFC
`define FSP_STATUS_RST   8'h00
`define FSP_FN_RSTDIS    0
`define FSP_FUNC_RST     8'h00
`define FSP_RP_SEL       7
`define FSP_RDPARAM_RST  8'h00
`define FSP_CTRL_MASK    8'h07
`define FSP_CTRL_RST     8'h00
`define FSP_CT_DIR       2
`define FSP_TXDATA_RST   8'h00

`define FSP_PIN_SCK      0
`define FSP_PIN_CS       1
`define FSP_PIN_D0       2
`define FSP_PIN_D1       3
`define FSP_PIN_D2       4
`define FSP_PIN_D3       5
`define FSP_PIN_RST      6
`define FSP_NPINS        7
`define FSP_PIN_INIT     7'h7E

`define FSP_STEP_SINGLE  4'h1
`define FSP_STEP_DUAL    4'h2
`define FSP_STEP_QUAD    4'h4
`define FSP_BYTE_BITS    4'h8
`define FSP_OE_SINGLE    4'h2
`define FSP_OE_DUAL      4'h3
`define FSP_OE_QUAD      4'hF

`endif

/* common/fspfe_pkg.sv */
// Types of the serial flash pin front end.
// Assumes fspfe_defs.svh is included by the files that need the constants.
package fspfe_pkg;
   typedef enum logic [1:0] {
      FSP_W_SINGLE,
      FSP_W_DUAL,
      FSP_W_QUAD
   } fspfe_width_t;

   typedef enum logic [1:0] {
      FSP_LS_RESET,
      FSP_LS_IDLE,
      FSP_LS_ACTIVE,
      FSP_LS_PAUSED
   } fspfe_link_t;
endpackage

/* common/fspfe_pin_if.sv */
// Synchronised pin levels and their edges, from the pin synchroniser to the core.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`include "fspfe_defs.svh"
interface fspfe_pin_if;
   logic [`FSP_NPINS-1:0] level;
   logic [`FSP_NPINS-1:0] rise;
   logic [`FSP_NPINS-1:0] fall;
   modport sync (output level, output rise, output fall);
   modport core (input level, input rise, input fall);
endinterface

/* design/fspfe_pin_sync.sv */
// Two-flop synchroniser with edge detect for every pin input.
// Assumes raw pins are asynchronous to clk; edges are reported from two cycles after reset, one cycle before history is valid.
`timescale 1ns/10ps
`include "fspfe_defs.svh"
module fspfe_pin_sync #(
   parameter int                      N    = `FSP_NPINS,
   parameter logic [`FSP_NPINS-1:0]   INIT = `FSP_PIN_INIT
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [N-1:0]          raw,
   fspfe_pin_if.sync                  pins
);
   logic [N-1:0] meta_q;
   logic [N-1:0] sync_q;
   logic [N-1:0] hist_q;
   logic [1:0]   valid_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q  <= INIT;
         sync_q  <= INIT;
         hist_q  <= INIT;
         valid_q <= 2'h0;
      end else begin
         meta_q  <= raw;
         sync_q  <= meta_q;
         hist_q  <= sync_q;
         valid_q <= {valid_q[0], 1'h1};
      end
   end

   // Edges from stale reset values would fake a select fall at power-up
   assign pins.level = sync_q;
   assign pins.rise  = valid_q[1] ? (sync_q & ~hist_q) : '0;
   assign pins.fall  = valid_q[1] ? (~sync_q & hist_q) : '0;
endmodule

/* design/fspfe_top.sv */
// Pin-level front end of a multi-width serial flash port with its control registers.
// Assumes the serial clock and select come from the host; all pins are oversampled by clk.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "fspfe_defs.svh"
module fspfe_top #(
   parameter logic HAS_RESET_PIN = 1'h1
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  sck,
   input  wire logic                  csN,
   input  wire logic [3:0]            dataLineIn,
   output logic      [3:0]            dataLineOut,
   output logic      [3:0]            dataLineOe,
   input  wire logic                  resetN,
   input  wire logic [2:0]            regAddr,
   input  wire logic [15:0]           regWrData,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output logic      [15:0]           regRdData,
   output logic                       standby
);
   import fspfe_pkg::*;

   fspfe_pin_if pins ();

   fspfe_pin_sync #(
      .N    (`FSP_NPINS),
      .INIT (`FSP_PIN_INIT)
   ) u_sync (
      .clk  (clk),
      .rst  (rst),
      .raw  ({resetN, dataLineIn, csN, sck}),
      .pins (pins)
   );

   fspfe_link_t  state_q;
   fspfe_link_t  state_d;
   fspfe_width_t effWidth;
   logic [7:0]   status_q;
   logic [7:0]   func_q;
   logic [7:0]   rdParam_q;
   logic [7:0]   ctrl_q;
   logic [7:0]   txData_q;
   logic         qeApplied_q;
   logic [7:0]   rxShift_q;
   logic [7:0]   rxByte_q;
   logic         rxFlag_q;
   logic [3:0]   rxCnt_q;
   logic [7:0]   txShift_q;
   logic [3:0]   txCnt_q;
   logic [3:0]   dataOut_q;
   logic [3:0]   oe_q;
   logic         standby_q;
   logic [15:0]  rdData_q;
   logic         dedRstOn;
   logic         sharedIsReset;
   logic         pauseFnOn;
   logic         resetMode;
   logic         csHigh;
   logic         pauseCond;
   logic         wpLow;
   logic         stWrBlocked;
   logic [3:0]   step;
   logic [3:0]   oeMask;
   logic [7:0]   rxNew;
   logic [3:0]   rxSum;
   logic [7:0]   txSrc;
   logic [7:0]   txNext;
   logic [3:0]   txSum;
   logic [3:0]   outBits;
   logic         rxEn;
   logic         txEn;
   logic         byteDone;
   logic         sckRise;
   logic         sckFall;
   logic         driveDir;

   assign csHigh   = pins.level[`FSP_PIN_CS];
   assign sckRise  = pins.rise[`FSP_PIN_SCK];
   assign sckFall  = pins.fall[`FSP_PIN_SCK];
   assign driveDir = ctrl_q[`FSP_CT_DIR];

   // Pin function selection follows the applied quad enable, not the raw bit
   always_comb begin
      dedRstOn      = HAS_RESET_PIN && !func_q[`FSP_FN_RSTDIS];
      sharedIsReset = !qeApplied_q && !dedRstOn && rdParam_q[`FSP_RP_SEL];
      pauseFnOn     = !qeApplied_q && !sharedIsReset;
      resetMode     = (dedRstOn && !pins.level[`FSP_PIN_RST])
                    || (sharedIsReset && !pins.level[`FSP_PIN_D3]);
      pauseCond     = pauseFnOn && !pins.level[`FSP_PIN_D3];
      wpLow         = !qeApplied_q && !pins.level[`FSP_PIN_D2];
      stWrBlocked   = status_q[`FSP_ST_LOCK] && wpLow;
   end

   always_comb begin
      case (fspfe_width_t'(ctrl_q[1:0]))
         FSP_W_DUAL: effWidth = FSP_W_DUAL;
         FSP_W_QUAD: effWidth = qeApplied_q ? FSP_W_QUAD : FSP_W_SINGLE;
         default:    effWidth = FSP_W_SINGLE;
      endcase
   end

   always_comb begin
      state_d = state_q;
      if (resetMode) begin
         state_d = FSP_LS_RESET;
      end else begin
         case (state_q)
            FSP_LS_RESET:  state_d = FSP_LS_IDLE;
            FSP_LS_IDLE: begin
               if (!csHigh && pins.fall[`FSP_PIN_CS]) begin
                  state_d = FSP_LS_ACTIVE;
               end
            end
            FSP_LS_ACTIVE: begin
               if (csHigh) begin
                  state_d = FSP_LS_IDLE;
               end else if (pauseCond) begin
                  state_d = FSP_LS_PAUSED;
               end
            end
            default: begin
               if (csHigh) begin
                  state_d = FSP_LS_IDLE;
               end else if (!pauseCond) begin
                  state_d = FSP_LS_ACTIVE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= FSP_LS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_comb begin
      txSrc = (txCnt_q == 4'h0) ? txData_q : txShift_q;
      case (effWidth)
         FSP_W_DUAL: begin
            step    = `FSP_STEP_DUAL;
            oeMask  = `FSP_OE_DUAL;
            rxNew   = {rxShift_q[5:0], pins.level[`FSP_PIN_D1], pins.level[`FSP_PIN_D0]};
            outBits = {dataOut_q[3:2], txSrc[7:6]};
            txNext  = {txSrc[5:0], 2'h0};
         end
         FSP_W_QUAD: begin
            step    = `FSP_STEP_QUAD;
            oeMask  = `FSP_OE_QUAD;
            rxNew   = {rxShift_q[3:0], pins.level[`FSP_PIN_D3:`FSP_PIN_D0]};
            outBits = txSrc[7:4];
            txNext  = {txSrc[3:0], 4'h0};
         end
         default: begin
            step    = `FSP_STEP_SINGLE;
            oeMask  = `FSP_OE_SINGLE;
            rxNew   = {rxShift_q[6:0], pins.level[`FSP_PIN_D0]};
            outBits = {dataOut_q[3:2], txSrc[7], dataOut_q[0]};
            txNext  = {txSrc[6:0], 1'h0};
         end
      endcase
      rxSum    = rxCnt_q + step;
      txSum    = txCnt_q + step;
      // Multi-width lanes are shared, so sampling stops while the device drives
      rxEn     = (state_q == FSP_LS_ACTIVE) && (state_d == FSP_LS_ACTIVE) && sckRise
               && ((effWidth == FSP_W_SINGLE) || !driveDir);
      txEn     = (state_q == FSP_LS_ACTIVE) && (state_d == FSP_LS_ACTIVE) && sckFall
               && driveDir;
      byteDone = rxEn && (rxSum == `FSP_BYTE_BITS);
   end

   // Counters survive a pause and are only cleared on deselect or reset
   always_ff @(posedge clk) begin
      if (rst || (state_d == FSP_LS_IDLE) || (state_d == FSP_LS_RESET)) begin
         rxCnt_q   <= 4'h0;
         rxShift_q <= 8'h00;
      end else if (rxEn) begin
         rxCnt_q   <= byteDone ? 4'h0 : rxSum;
         rxShift_q <= rxNew;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rxByte_q <= 8'h00;
      end else if (byteDone) begin
         rxByte_q <= rxNew;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || (state_d == FSP_LS_IDLE) || (state_d == FSP_LS_RESET)) begin
         txCnt_q   <= 4'h0;
         txShift_q <= 8'h00;
      end else if (txEn) begin
         txCnt_q   <= (txSum == `FSP_BYTE_BITS) ? 4'h0 : txSum;
         txShift_q <= txNext;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dataOut_q <= 4'h0;
      end else if (txEn) begin
         dataOut_q <= outBits;
      end
   end

   // Enables follow the next state so the pins float in the cycle the state leaves
   always_ff @(posedge clk) begin
      if (rst) begin
         oe_q      <= 4'h0;
         standby_q <= 1'h1;
      end else begin
         oe_q      <= ((state_d == FSP_LS_ACTIVE) && driveDir) ? oeMask : 4'h0;
         standby_q <= (state_d == FSP_LS_IDLE);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= `FSP_STATUS_RST;
      end else if (regWr && (regAddr == `FSP_REG_STATUS) && !stWrBlocked) begin
         status_q <= regWrData[7:0] & `FSP_STATUS_MASK;
      end
   end

   // One cycle of lag keeps a pin from changing role in the middle of the write
   always_ff @(posedge clk) begin
      if (rst) begin
         qeApplied_q <= 1'h0;
      end else begin
         qeApplied_q <= status_q[`FSP_ST_QE];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         func_q    <= `FSP_FUNC_RST;
         rdParam_q <= `FSP_RDPARAM_RST;
         ctrl_q    <= `FSP_CTRL_RST;
         txData_q  <= `FSP_TXDATA_RST;
      end else if (regWr) begin
         if (regAddr == `FSP_REG_FUNC) begin
            func_q <= {7'h00, regWrData[`FSP_FN_RSTDIS]};
         end else if (regAddr == `FSP_REG_RDPARAM) begin
            rdParam_q <= {regWrData[`FSP_RP_SEL], 7'h00};
         end else if (regAddr == `FSP_REG_CTRL) begin
            ctrl_q <= regWrData[7:0] & `FSP_CTRL_MASK;
         end else if (regAddr == `FSP_REG_TXDATA) begin
            txData_q <= regWrData[7:0];
         end
      end
   end

   // A byte finishing in the cycle of the clearing read keeps the flag set
   always_ff @(posedge clk) begin
      if (rst) begin
         rxFlag_q <= 1'h0;
      end else if (byteDone) begin
         rxFlag_q <= 1'h1;
      end else if (regRd && (regAddr == `FSP_REG_RXDATA)) begin
         rxFlag_q <= 1'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdData_q <= 16'h0000;
      end else if (!regRd) begin
         rdData_q <= 16'h0000;
      end else if (regAddr == `FSP_REG_STATUS) begin
         rdData_q <= {8'h00, status_q};
      end else if (regAddr == `FSP_REG_FUNC) begin
         rdData_q <= {8'h00, func_q};
      end else if (regAddr == `FSP_REG_RDPARAM) begin
         rdData_q <= {8'h00, rdParam_q};
      end else if (regAddr == `FSP_REG_CTRL) begin
         rdData_q <= {8'h00, ctrl_q};
      end else if (regAddr == `FSP_REG_TXDATA) begin
         rdData_q <= {8'h00, txData_q};
      end else if (regAddr == `FSP_REG_RXDATA) begin
         rdData_q <= {4'h0, qeApplied_q, state_q, rxFlag_q, rxByte_q};
      end else begin
         rdData_q <= 16'h0000;
      end
   end

   assign dataLineOut = dataOut_q;
   assign dataLineOe  = oe_q;
   assign regRdData   = rdData_q;
   assign standby     = standby_q;

   property p_desel_hiz;
      @(posedge clk) disable iff (rst)
      csHigh |=> (oe_q == 4'h0) && (standby_q || (state_q == FSP_LS_RESET));
   endproperty
   a_desel_hiz: assert property (p_desel_hiz) else $error("outputs driven while deselected");

   property p_ignore_desel;
      @(posedge clk) disable iff (rst)
      (state_q == FSP_LS_IDLE) && sckRise |=> (rxCnt_q == 4'h0) && $stable(rxByte_q);
   endproperty
   a_ignore_desel: assert property (p_ignore_desel) else $error("input taken while deselected");

   property p_need_fall;
      @(posedge clk) disable iff (rst)
      (state_q == FSP_LS_IDLE) && !pins.fall[`FSP_PIN_CS] |=> (state_q != FSP_LS_ACTIVE);
   endproperty
   a_need_fall: assert property (p_need_fall) else $error("selected without a select fall");

   property p_single_byte;
      @(posedge clk) disable iff (rst)
      rxEn && (effWidth == FSP_W_SINGLE) && (rxCnt_q == 4'h7)
      |=> rxFlag_q && (rxCnt_q == 4'h0) && (rxByte_q[0] == $past(pins.level[`FSP_PIN_D0]));
   endproperty
   a_single_byte: assert property (p_single_byte) else $error("single byte not completed");

   property p_out_on_fall;
      @(posedge clk) disable iff (rst)
      !sckFall |=> $stable(dataOut_q);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("output changed off falling clock");

   property p_quad_lanes;
      @(posedge clk) disable iff (rst)
      !qeApplied_q |=> (oe_q[3:2] == 2'h0);
   endproperty
   a_quad_lanes: assert property (p_quad_lanes) else $error("upper lanes driven without quad");

   property p_wp_block;
      @(posedge clk) disable iff (rst)
      regWr && (regAddr == `FSP_REG_STATUS) && status_q[`FSP_ST_LOCK] && !qeApplied_q
      && !pins.level[`FSP_PIN_D2] |=> $stable(status_q);
   endproperty
   a_wp_block: assert property (p_wp_block) else $error("protected status write landed");

   property p_pause_hiz;
      @(posedge clk) disable iff (rst)
      (state_q == FSP_LS_PAUSED) |-> (oe_q == 4'h0) && $stable(rxCnt_q) && $stable(txCnt_q);
   endproperty
   a_pause_hiz: assert property (p_pause_hiz) else $error("pause drove pins or lost sequence");

   property p_reset_hiz;
      @(posedge clk) disable iff (rst)
      resetMode |=> (state_q == FSP_LS_RESET) && (oe_q == 4'h0);
   endproperty
   a_reset_hiz: assert property (p_reset_hiz) else $error("reset mode not entered");

   property p_qe_apply;
      @(posedge clk) disable iff (rst)
      $changed(status_q[`FSP_ST_QE]) |-> (qeApplied_q != status_q[`FSP_ST_QE])
      ##1 (qeApplied_q == $past(status_q[`FSP_ST_QE]));
   endproperty
   a_qe_apply: assert property (p_qe_apply) else $error("quad enable applied at wrong time");
endmodule

/* bench/fspfe_host_model.sv */
// Behavioural serial host: mode 0 clock, select, data lines and the control pins.
// Assumes the bench resolves each wire from both parties' enables and feeds lineLvl back.
`timescale 1ns/10ps
module fspfe_host_model (
   input  wire logic       clk,
   input  wire logic [3:0] lineLvl,
   output logic            sck,
   output logic            csN,
   output logic [3:0]      hostOe,
   output logic [3:0]      hostOut,
   output logic            resetN
);
   logic [1:0] ctlPins = 2'h3;

   initial begin
      sck = 1'h0; // Clock idles low between frames
      csN = 1'h1;
      hostOe = 4'hC;
      hostOut = 4'hC;
      resetN = 1'h1;
   end

   // Select falls before any bit of a selected frame is sent
   task automatic select();
      @(posedge clk);
      csN <= 1'h0; // Fresh select fall per frame
      repeat (4) @(posedge clk);
   endtask

   // One bit period of 8 clk; data changes with the falling clock so it is stable at the rise
   task automatic step(input logic [3:0] dm, om, val, output logic [3:0] seen);
      @(posedge clk);
      hostOe <= om | (4'hC & ~dm); // Released lines left to the device
      hostOut <= (val & dm) | ({ctlPins, 2'h0} & ~dm); // Data set at fall
      sck <= 1'h0;
      repeat (4) @(posedge clk);
      sck <= 1'h1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      seen = lineLvl;
      @(posedge clk);
   endtask

   // Clock back low before select rises; lines handed back only after the device lets go
   task automatic endFrame();
      @(posedge clk);
      sck <= 1'h0; // Idle low
      repeat (4) @(posedge clk);
      csN <= 1'h1;
      repeat (6) @(posedge clk);
      hostOe <= 4'hC;
      hostOut <= {ctlPins, 2'h0};
   endtask

   task automatic pins(input logic wp, hold, rstN);
      @(posedge clk);
      ctlPins <= {hold, wp};
      hostOut[3:2] <= {hold, wp};
      hostOe[3:2] <= 2'h3;
      resetN <= rstN;
      repeat (4) @(posedge clk);
   endtask
endmodule

/* bench/fspfe_test.sv */
// Self-checking bench of the flash pin front end driven by the behavioural serial host.
// Assumes the defines header and package are compiled first; serial clock period 400 ns.
`timescale 1ns/10ps
`include "fspfe_defs.svh"
module fspfe_test;
   import fspfe_pkg::*;
   typedef struct packed {
      logic [2:0] ctrl;
      logic       qe;
      logic [3:0] dm;
      logic [7:0] data;
      logic [3:0] oe;
   } fspfe_row_t;
   typedef struct packed {
      logic       func, sel, qe, hold, rstN;
      logic [1:0] st;
      logic [3:0] oe;
      logic [1:0] after;
   } fspfe_flt_t;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic        regWr = 1'h0;
   logic        regRd = 1'h0;
   logic [2:0]  regAddr = 3'h0;
   logic [15:0] regWrData = 16'h0000;
   logic [3:0]  floatPat = 4'h5;
   logic        sck, csN, resetN, standby;
   logic [15:0] regRdData, rd, prev;
   logic [3:0]  dataLineIn, dataLineOut, dataLineOe, hostOe, hostOut, hostLvl, seen, om;
   logic [7:0]  got, sh;
   int          nb;
   int          miscompares = 0;
   int          checkCount = 0;
   fspfe_row_t  row;
   fspfe_flt_t  fl;
   fspfe_row_t  rows [8] = '{
      '{3'h0, 1'h0, 4'h1, 8'hA5, 4'h0}, '{3'h1, 1'h0, 4'h3, 8'h3C, 4'h0},
      '{3'h2, 1'h1, 4'hF, 8'h96, 4'h0}, '{3'h2, 1'h0, 4'h1, 8'h69, 4'h0},
      '{3'h3, 1'h0, 4'h1, 8'h81, 4'h0}, '{3'h4, 1'h0, 4'h1, 8'hC3, 4'h2},
      '{3'h5, 1'h0, 4'h3, 8'h5A, 4'h3}, '{3'h6, 1'h1, 4'hF, 8'hE7, 4'hF}};
   fspfe_flt_t  flts [6] = '{
      '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 2'h0, 4'h0, 2'h1},
      '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 2'h2, 4'h2, 2'h2},
      '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 2'h0, 4'h0, 2'h1},
      '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 2'h3, 4'h0, 2'h2},
      '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 2'h2, 4'h2, 2'h2},
      '{1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 2'h3, 4'h0, 2'h2}};
   logic [16:0] prot [6] = '{{1'h1, 8'h80, 8'h80}, {1'h0, 8'h00, 8'h80},
      {1'h1, 8'hC4, 8'hC4}, {1'h0, 8'h04, 8'h04}, {1'h0, 8'h3F, 8'h3C}, {1'h1, 8'h00, 8'h00}};

   // Undriven lines toggle so a stale value can never pass for data
   assign hostLvl = (hostOe & hostOut) | (~hostOe & floatPat);
   assign dataLineIn = rst ? hostLvl : (dataLineOe & dataLineOut) | (~dataLineOe & hostLvl);
   always @(posedge clk) floatPat <= ~floatPat;
   initial forever #25 clk = ~clk;

   fspfe_top fspfe_top_inst (.clk(clk), .rst(rst), .sck(sck), .csN(csN),
      .dataLineIn(dataLineIn), .dataLineOut(dataLineOut), .dataLineOe(dataLineOe),
      .resetN(resetN), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .standby(standby));
   fspfe_host_model fspfe_host_model_inst (.clk(clk), .lineLvl(dataLineIn), .sck(sck),
      .csN(csN), .hostOe(hostOe), .hostOut(hostOut), .resetN(resetN));

   task automatic endSim();
      $display("Checks made %0d, mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] exp, act);
      checkCount++;
      if (act !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, act);
      end
   endtask

   task automatic regWrite(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'h1;
      @(posedge clk);
      regWr <= 1'h0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic regRead(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge clk);
      regRd <= 1'h0;
      @(negedge clk);
      d = regRdData;
   endtask

   initial begin
      #1000000;
      miscompares++;
      endSim();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      @(negedge clk);
      check("standby", 16'h0001, {15'h0, standby});
      check("oe idle", 16'h0000, {12'h0, dataLineOe});
      regWrite(3'h6, 16'h00FF);
      for (int a = 0; a < 8; a++) begin
         regRead(a[2:0], rd);
         check("reset reg", (a == 5) ? 16'h0200 : 16'h0000, rd);
      end
      for (int p = 0; p < 6; p++) begin
         fspfe_host_model_inst.pins(prot[p][16], 1'h1, 1'h1);
         regWrite(`FSP_REG_STATUS, {8'h0, prot[p][15:8]});
         regRead(`FSP_REG_STATUS, rd);
         check("status", {8'h0, prot[p][7:0]}, rd);
      end
      for (int r = 0; r < 8; r++) begin
         row = rows[r];
         nb = (row.dm == 4'hF) ? 4 : (row.dm == 4'h3) ? 2 : 1;
         om = (row.ctrl[2] && nb > 1) ? 4'h0 : row.dm;
         regWrite(`FSP_REG_STATUS, {9'h0, row.qe, 6'h0});
         regWrite(`FSP_REG_CTRL, {13'h0, row.ctrl});
         regWrite(`FSP_REG_TXDATA, {8'h0, row.data});
         fspfe_host_model_inst.select();
         got = 8'h00;
         for (int k = 0; k <= 8 / nb; k++) begin
            sh = row.data << (nb * k);
            fspfe_host_model_inst.step(row.dm, om, 4'(sh >> (8 - nb)), seen);
            if (k > 0) got = (nb == 1) ? {got[6:0], seen[1]} : 8'((got << nb) | (seen & row.dm));
            if (k == 1) begin
               @(negedge clk);
               check("oe", {12'h0, row.oe}, {12'h0, dataLineOe});
            end
         end
         fspfe_host_model_inst.endFrame();
         check("standby", 16'h0001, {15'h0, standby});
         check("oe off", 16'h0000, {12'h0, dataLineOe});
         regRead(`FSP_REG_RXDATA, rd);
         if (om != 4'h0) check("rx", {4'h0, row.qe, 3'h3, row.data}, rd);
         if (row.ctrl[2]) check("tx", {8'h0, row.data}, {8'h0, got});
      end
      regWrite(`FSP_REG_STATUS, 16'h0000);
      regWrite(`FSP_REG_CTRL, 16'h0004);
      fspfe_host_model_inst.select();
      for (int k = 0; k < 10; k++) begin
         if (k == 3) begin
            fspfe_host_model_inst.pins(1'h1, 1'h0, 1'h1);
            @(negedge clk);
            check("oe paused", 16'h0000, {12'h0, dataLineOe});
            regRead(`FSP_REG_RXDATA, rd);
            check("paused", 16'h0003, {14'h0, rd[10:9]});
         end
         if (k == 5) fspfe_host_model_inst.pins(1'h1, 1'h1, 1'h1);
         sh = 8'hB2 << ((k < 5) ? k : k - 2);
         fspfe_host_model_inst.step(4'h1, 4'h1, {3'h0, sh[7] ^ (k == 3 || k == 4)}, seen);
         if (k == 5) check("oe resumed", 16'h0002, {12'h0, dataLineOe});
      end
      fspfe_host_model_inst.endFrame();
      regRead(`FSP_REG_RXDATA, rd);
      check("rx paused", 16'h01B2, {7'h0, rd[8:0]});
      for (int f = 0; f < 6; f++) begin
         fl = flts[f];
         regWrite(`FSP_REG_STATUS, {9'h0, fl.qe, 6'h0});
         regWrite(`FSP_REG_FUNC, {15'h0, fl.func});
         regWrite(`FSP_REG_RDPARAM, {8'h0, fl.sel, 7'h0});
         fspfe_host_model_inst.select();
         fspfe_host_model_inst.step(4'h1, 4'h1, 4'h1, seen);
         fspfe_host_model_inst.pins(1'h1, fl.hold, fl.rstN);
         @(negedge clk);
         check("pin oe", {12'h0, fl.oe}, {12'h0, dataLineOe});
         regRead(`FSP_REG_RXDATA, rd);
         check("pin state", {14'h0, fl.st}, {14'h0, rd[10:9]});
         fspfe_host_model_inst.pins(1'h1, 1'h1, 1'h1);
         regRead(`FSP_REG_RXDATA, rd);
         check("released", {14'h0, fl.after}, {14'h0, rd[10:9]});
         fspfe_host_model_inst.endFrame();
      end
      regRead(`FSP_REG_CTRL, rd);
      check("kept ctrl", 16'h0004, rd);
      regRead(`FSP_REG_RXDATA, prev);
      for (int k = 0; k < 9; k++) fspfe_host_model_inst.step(4'h1, 4'h1, 4'h1, seen);
      fspfe_host_model_inst.endFrame();
      regRead(`FSP_REG_RXDATA, rd);
      check("deselected", {8'h02, prev[7:0]}, {4'h0, rd[11:0]});
      check("standby", 16'h0001, {15'h0, standby});
      endSim();
   end
endmodule
